//--- bench/far_side_model.sv
// Far side: input supply, power stages, current converter.
// Assumes the bench commands pin, input, stage and ADC conditions; the rest are tied off; one clock.
`timescale 1ns/10ps
module far_side_model
    import fault_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        pin_cmd,
    input  wire logic        vin_cmd,
    input  wire logic        uv_cmd,
    input  wire logic        hot_cmd,
    input  wire logic [3:0]  flt_cmd,
    input  wire logic [3:0]  tlow_cmd,
    input  wire logic [11:0] iout_cmd,
    input  wire logic [11:0] vout_cmd,
    output sense_t           sense,
    output logic [11:0]      iout_sample,
    output logic [11:0]      vout_sample,
    output logic             iout_sample_valid
);
    logic [1:0] div = 2'h0;
    always_comb
    begin
        sense                 = '0;
        sense.ctrl_pin        = pin_cmd;
        sense.vin_above_on    = vin_cmd;
        sense.vin_below_off   = ~vin_cmd;
        sense.vin_uv          = uv_cmd;
        sense.ctrl_temp_cool  = 1'b1;
        sense.stage_hot       = {3'h0, hot_cmd};
        sense.stage_cool      = {3'h7, ~hot_cmd};
        sense.stage_fault_ind = flt_cmd;
        sense.stage_temp_low  = tlow_cmd;
    end
    always_ff @(posedge hclk)
    begin
        div               <= div + 2'h1;
        iout_sample_valid <= (div == 2'h3);
        iout_sample       <= (div == 2'h3) ? iout_cmd : ~iout_cmd;
        vout_sample       <= (div == 2'h3) ? vout_cmd : ~vout_cmd;
    end
endmodule : far_side_model

//--- bench/tb_power_fault_supervisor.sv
// Self-checking bench for the power fault supervisor.
// Assumes the far-side model feeds all sense pins.
`timescale 1ns/10ps
module tb_power_fault_supervisor
    import fault_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, iv, me, pt, pl, sr;
    logic pin_cmd = 0, vin_cmd = 0, uv_cmd = 0, hot_cmd = 0;
    logic [3:0] flt_cmd = 4'h0, tlow_cmd = 4'h0;
    logic [11:0] iout_cmd = 12'h000, vout_cmd = 12'h800, is, vs;
    logic [7:0] rr;
    sense_t sense;
    int n_fail = 0, check_count = 0;
    wire [3:0] outs = {sr, pl, pt, me};
    far_side_model fm (.hclk(hclk), .pin_cmd(pin_cmd), .vin_cmd(vin_cmd), .uv_cmd(uv_cmd),
        .hot_cmd(hot_cmd), .flt_cmd(flt_cmd), .tlow_cmd(tlow_cmd), .iout_cmd(iout_cmd), .vout_cmd(vout_cmd),
        .sense(sense), .iout_sample(is), .vout_sample(vs), .iout_sample_valid(iv));
    power_fault_supervisor #(.TEMP_CYC(10), .RFINE_CYC(20), .RCOARSE_CYC(30), .RTEMP_CYC(40)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense),
        .vout_sample(vs), .vout_sample_valid(iv), .iout_sample(is),
        .iout_sample_valid(iv), .modulator_enable(me), .pwm_tristate(pt),
        .pwm_force_low(pl), .softoff_req(sr), .ramp_down_rate(rr));
    initial forever #4 hclk = ~hclk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task wt(input int k, input logic v);
        for (int i = 0; i < 60 && outs[k] !== v; i++) @(posedge hclk);
        @(posedge hclk);
    endtask : wt
    task cycle_pin();
        pin_cmd <= 0;
        repeat (6) @(posedge hclk);
        pin_cmd <= 1;
        wt(0, 1);
    endtask : cycle_pin
    task t_reset();
        chk("tristate", 1, pt);
        bus(0, A_CONTROL, 0); chk("control", 1, rd);
        chk("okay", 0, hresp);
        bus(0, A_RAMP, 0); chk("ramp", 8'h01, rd);
        chk("ramp out", 8'h01, rr);
        bus(0, 8'hFC, 0); chk("unmapped", 0, rd);
        pin_cmd <= 1;
        tlow_cmd <= 4'h2;
        repeat (8) @(posedge hclk);
        bus(0, A_STATUS, 0); chk("low input", 1, rd[10]);
        chk("enable", 0, me);
        vin_cmd <= 1;
        repeat (8) @(posedge hclk);
        bus(0, A_STATUS, 0); chk("start block", 2'b10, rd[11:10]);
        chk("blocked", 0, me);
        tlow_cmd <= 4'h0;
        wt(0, 1); chk("started", 2'b01, {pt, me});
        bus(1, A_RAMP, 32'h3C);
        bus(0, A_RAMP, 0); chk("ramp set", 8'h3C, rr);
        chk("ramp read", 8'h3C, rd);
    endtask : t_reset
    task t_ocp();
        bus(1, A_IOUT_LIM, 32'h100);
        iout_cmd <= 12'h200;
        wt(1, 1); chk("ocp tristate", 1, pt);
        iout_cmd <= 12'h010;
        repeat (30) @(posedge hclk);
        chk("ocp latched", 0, me);
        cycle_pin(); chk("pin clear", 1, me);
    endtask : t_ocp
    task t_low();
        bus(1, A_CFG + 8'h1C, 32'h0080_0000);
        flt_cmd <= 4'h1;
        wt(2, 1); chk("force low", 1, pl);
        flt_cmd <= 4'h0;
        bus(0, A_STAGE, 0); chk("stage flag", 1, rd[3:0]);
        bus(1, A_STAGE, 32'hFFF);
        bus(0, A_STAGE, 0); chk("stage clear", 0, rd[3:0]);
        cycle_pin(); chk("low cleared", 0, pl);
    endtask : t_low
    task t_vout();
        bus(1, A_VUV_WRN, 32'h600);
        bus(1, A_VUV_FLT, 32'h400);
        bus(1, A_VOV_WRN, 32'hA00);
        vout_cmd <= 12'h500;
        repeat (6) @(posedge hclk);
        bus(0, A_STATUS, 0); chk("uv warn", 4'h1, rd[11:8]);
        chk("warn only", 1, me);
        vout_cmd <= 12'hB00;
        repeat (6) @(posedge hclk);
        bus(0, A_STATUS, 0); chk("ov warn", 4'h2, rd[11:8]);
        bus(1, A_CFG + 8'h04, 32'h2);
        vout_cmd <= 12'h300;
        repeat (4) @(posedge hclk);
        vout_cmd <= 12'h800;
        repeat (FINE_CYC / 2) @(posedge hclk);
        chk("discard", 2'b01, {pt, me});
        vout_cmd <= 12'h300;
        repeat (FINE_CYC / 2) @(posedge hclk);
        chk("delay hold", 1, me);
        repeat (2 * FINE_CYC + 30) @(posedge hclk);
        chk("uv fault", 2'b10, {pt, me});
        vout_cmd <= 12'h800;
        cycle_pin(); chk("uv cleared", 1, me);
    endtask : t_vout
    task t_temp();
        hot_cmd <= 1;
        wt(3, 1); chk("soft stop", 2'b11, {sr, me});
        hot_cmd <= 0;
        wt(3, 0); chk("temp restart", 2'b01, {sr, me});
    endtask : t_temp
    task t_uv();
        uv_cmd <= 1;
        wt(1, 1); chk("uv tristate", 2'b10, {pt, me});
        uv_cmd <= 0;
        wt(0, 1); chk("uv retry", 1, me);
        vin_cmd <= 0;
        wt(3, 1); chk("soft off", 1, sr);
    endtask : t_uv
    task end_of_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        t_reset();
        t_ocp();
        t_low();
        t_vout();
        t_temp();
        t_uv();
        end_of_test();
    end
    initial
    begin
        #160000;
        n_fail++;
        end_of_test();
    end
endmodule : tb_power_fault_supervisor

//--- hw/fault_pkg.sv
// Constants, types and defaults for the power fault supervisor.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
package fault_pkg;
    localparam logic [7:0] A_CONTROL = 8'h00;
    localparam logic [7:0] A_STATUS  = 8'h04;
    localparam logic [7:0] A_STAGE   = 8'h08;
    localparam logic [7:0] A_VUV_WRN = 8'h0C;
    localparam logic [7:0] A_VUV_FLT = 8'h10;
    localparam logic [7:0] A_VOV_WRN = 8'h14;
    localparam logic [7:0] A_IOUT_LIM = 8'h18;
    localparam logic [7:0] A_RAMP    = 8'h1C;
    localparam logic [7:0] A_CFG     = 8'h20;
    localparam int         NSRC      = 8;
    localparam int         NSTAGE    = 4;
    localparam int         SRC_VOUT_OV = 0;
    localparam int         SRC_VOUT_UV = 1;
    localparam int         SRC_VIN_OV  = 2;
    localparam int         SRC_VIN_UV  = 3;
    localparam int         SRC_OCP     = 4;
    localparam int         SRC_CTRL_OT = 5;
    localparam int         SRC_STAGE_OT = 6;
    localparam int         SRC_STAGE_FLT = 7;
    localparam logic [NSRC-1:0] UNLIMITED_MASK = 8'h68;
    localparam logic [NSRC-1:0] SOFT_MASK      = 8'h60;
    localparam logic [NSRC-1:0] TEMP_MASK      = 8'h60;
    localparam logic [2:0] RETRY_UNLIMITED = 3'h7;
    localparam logic [2:0] RETRY_NONE      = 3'h0;
    localparam logic [0:0] CONTROL_RESET   = 1'h1;
    localparam logic [11:0] VUV_WRN_RESET  = 12'h000;
    localparam logic [11:0] VUV_FLT_RESET  = 12'h000;
    localparam logic [11:0] VOV_WRN_RESET  = 12'hFFF;
    localparam logic [11:0] IOUT_LIM_RESET = 12'hFFF;
    localparam logic [7:0]  RAMP_RESET     = 8'h01;
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int FINE_STEP_NS   = 1500;
    localparam int FINE_MAX_NS    = 327000;
    localparam int COARSE_STEP_NS = 15000;
    localparam int COARSE_MAX_NS  = 3270000;
    localparam int TEMP_STEP_US   = 5000;
    localparam int TEMP_MAX_US    = 900000;
    localparam int RETRY_SCALE    = 100;
    localparam int FINE_CYC   = (FINE_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int COARSE_CYC = (COARSE_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TEMP_CYC_DEF = (TEMP_STEP_US * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS * 1000;
    localparam logic [8:0] FINE_LIMIT   = 9'(FINE_MAX_NS / FINE_STEP_NS);
    localparam logic [8:0] COARSE_LIMIT = 9'(COARSE_MAX_NS / COARSE_STEP_NS);
    localparam logic [8:0] TEMP_LIMIT   = 9'(TEMP_MAX_US / TEMP_STEP_US);

    typedef enum logic [1:0] {RESP_HIZ, RESP_LOW, RESP_SOFT} resp_t;
    typedef enum logic [2:0] {S_IDLE, S_DELAY, S_FAULT, S_RETRY, S_LATCH} src_state_t;

    typedef struct packed {
        logic [1:0] response;
        logic [2:0] retries;
        logic [9:0] retry_delay;
        logic [9:0] fault_delay;
    } cfg_t;

    typedef struct packed {
        logic              ctrl_pin;
        logic              vin_above_on;
        logic              vin_below_off;
        logic              vin_ov;
        logic              vin_uv;
        logic              vout_ov_fast;
        logic              vout_uv_fast;
        logic              ctrl_temp_hot;
        logic              ctrl_temp_cool;
        logic [NSTAGE-1:0] stage_hot;
        logic [NSTAGE-1:0] stage_cool;
        logic [NSTAGE-1:0] stage_fault_ind;
        logic [NSTAGE-1:0] stage_temp_low;
    } sense_t;

    function automatic cfg_t default_cfg(input int idx);
        cfg_t c;
        c = '0;
        c.retries  = UNLIMITED_MASK[idx] ? RETRY_UNLIMITED : RETRY_NONE;
        c.response = SOFT_MASK[idx] ? RESP_SOFT : RESP_HIZ;
        return c;
    endfunction : default_cfg
endpackage : fault_pkg

//--- hw/power_fault_supervisor.sv
// Fault grading, delay, retry and modulator response for a multi-phase controller.
// Assumes comparator flags arrive asynchronously on pins and ADC samples on hclk.
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
module power_fault_supervisor
    import fault_pkg::*;
#(
    parameter int TEMP_CYC    = TEMP_CYC_DEF,
    parameter int RFINE_CYC   = FINE_CYC * RETRY_SCALE,
    parameter int RCOARSE_CYC = COARSE_CYC * RETRY_SCALE,
    parameter int RTEMP_CYC   = TEMP_CYC_DEF * RETRY_SCALE
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire sense_t      sense,
    input  wire logic [11:0] vout_sample,
    input  wire logic        vout_sample_valid,
    input  wire logic [11:0] iout_sample,
    input  wire logic        iout_sample_valid,
    output logic             modulator_enable,
    output logic             pwm_tristate,
    output logic             pwm_force_low,
    output logic             softoff_req,
    output logic [7:0]       ramp_down_rate
);
    localparam int NUNIT = 6;
    localparam int unit_period [NUNIT] = '{FINE_CYC, COARSE_CYC, TEMP_CYC, RFINE_CYC, RCOARSE_CYC, RTEMP_CYC};

    sense_t            s1;
    sense_t            s;
    logic              pin_prev;
    logic              op_enable;
    logic [11:0]       vuv_wrn;
    logic [11:0]       vuv_flt;
    logic [11:0]       vov_wrn;
    logic [11:0]       iout_lim;
    cfg_t              cfg [NSRC];
    logic [11:0]       stage_status;
    logic              uv_fault_adc;
    logic              uv_warn;
    logic              ov_warn;
    logic              ocp_hit;
    logic              vin_ok;
    logic              mod_started;
    logic [7:0]        addr_q;
    logic              wr_q;
    logic [NUNIT-1:0]  tick;
    logic [NSRC-1:0]   active;
    logic [NSRC-1:0]   act_hiz;
    logic [NSRC-1:0]   act_low;
    logic [NSRC-1:0]   act_soft;
    logic [31:0]       rd_word;

    // Clamp a delay field to its range
    function automatic logic [8:0] delay_count(input logic [9:0] f, input logic temp);
        logic [8:0] lim;
        lim = temp ? TEMP_LIMIT : (f[9] ? COARSE_LIMIT : FINE_LIMIT);
        return (f[8:0] > lim) ? lim : f[8:0];
    endfunction : delay_count

    // Pick the step tick for a delay field
    function automatic logic tick_sel(input logic [9:0] f, input logic temp, input logic [2:0] t);
        return temp ? t[2] : (f[9] ? t[1] : t[0]);
    endfunction : tick_sel

    // Two-flop synchroniser on all pin flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1       <= '0;
            s        <= '0;
            pin_prev <= 1'b0;
        end
        else
        begin
            s1       <= sense;
            s        <= s1;
            pin_prev <= s.ctrl_pin;
        end
    end

    wire pin_fall = pin_prev & ~s.ctrl_pin;

    // Step dividers for fault and retry units
    generate
        for (genvar u = 0; u < NUNIT; u++)
        begin : g_unit
            logic [25:0] cnt;
            wire         wrap = (cnt == 26'(unit_period[u] - 1));
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    cnt     <= '0;
                    tick[u] <= 1'b0;
                end
                else
                begin
                    cnt     <= wrap ? 26'h0000000 : cnt + 26'h0000001;
                    tick[u] <= wrap;
                end
            end
        end
    endgenerate

    // ADC sample grading
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            uv_fault_adc <= 1'b0;
            uv_warn      <= 1'b0;
            ov_warn      <= 1'b0;
            ocp_hit      <= 1'b0;
        end
        else
        begin
            if (vout_sample_valid)
            begin
                uv_fault_adc <= vout_sample < vuv_flt;
                uv_warn      <= (vout_sample < vuv_wrn) && (vout_sample >= vuv_flt);
                ov_warn      <= vout_sample > vov_wrn;
            end
            if (iout_sample_valid)
            begin
                ocp_hit <= iout_sample > iout_lim;
            end
        end
    end

    wire [NSRC-1:0] cond = {|s.stage_fault_ind, |s.stage_hot, s.ctrl_temp_hot, ocp_hit,
                            s.vin_uv, s.vin_ov, s.vout_uv_fast | uv_fault_adc, s.vout_ov_fast};
    wire [NSRC-1:0] restart_ok = {~cond[7], &s.stage_cool, s.ctrl_temp_cool, ~cond[4:0]};

    // Per-source delay, retry and latch sequencing
    generate
        for (genvar i = 0; i < NSRC; i++)
        begin : g_src
            src_state_t state;
            src_state_t next_state;
            logic [8:0] timer;
            logic [8:0] next_timer;
            logic [2:0] used;
            logic [2:0] next_used;
            wire  [8:0] dcnt  = delay_count(cfg[i].fault_delay, TEMP_MASK[i]);
            wire  [8:0] rcnt  = delay_count(cfg[i].retry_delay, TEMP_MASK[i]);
            wire        dtick = tick_sel(cfg[i].fault_delay, TEMP_MASK[i], tick[2:0]);
            wire        rtick = tick_sel(cfg[i].retry_delay, TEMP_MASK[i], tick[5:3]);
            wire        can_retry = (cfg[i].retries == RETRY_UNLIMITED) || (used < cfg[i].retries);

            always_comb
            begin
                next_state = state;
                next_timer = timer;
                next_used  = used;
                case (state)
                    S_IDLE:
                    begin
                        if (cond[i])
                        begin
                            next_state = (dcnt == 9'h000) ? S_FAULT : S_DELAY;
                            next_timer = dcnt;
                        end
                    end
                    S_DELAY:
                    begin
                        if (!cond[i])
                            next_state = S_IDLE;
                        else if (timer == 9'h000)
                            next_state = S_FAULT;
                        else if (dtick)
                            next_timer = timer - 9'h001;
                    end
                    S_FAULT:
                    begin
                        if (can_retry)
                        begin
                            next_state = S_RETRY;
                            next_timer = rcnt;
                            next_used  = (cfg[i].retries == RETRY_UNLIMITED) ? used : used + 3'h1;
                        end
                        else
                            next_state = S_LATCH;
                    end
                    S_RETRY:
                    begin
                        if (timer == 9'h000)
                        begin
                            next_state = restart_ok[i] ? S_IDLE : S_FAULT;
                            next_used  = restart_ok[i] ? 3'h0 : used;
                        end
                        else if (rtick)
                            next_timer = timer - 9'h001;
                    end
                    S_LATCH:
                    begin
                        if (pin_fall)
                        begin
                            next_state = S_IDLE;
                            next_used  = 3'h0;
                        end
                    end
                    default:
                        next_state = S_IDLE;
                endcase
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    state <= S_IDLE;
                    timer <= '0;
                    used  <= '0;
                end
                else
                begin
                    state <= next_state;
                    timer <= next_timer;
                    used  <= next_used;
                end
            end

            assign active[i]   = (state == S_FAULT) || (state == S_RETRY) || (state == S_LATCH);
            assign act_low[i]  = active[i] && (cfg[i].response == RESP_LOW);
            assign act_soft[i] = active[i] && (cfg[i].response == RESP_SOFT);
            assign act_hiz[i]  = active[i] && !act_low[i] && !act_soft[i];

            a_delay_discard: assert property (@(posedge hclk) disable iff (!hresetn)
                (state == S_DELAY) && !cond[i] |=> (state == S_IDLE))
                else $error("vanished detection not discarded");
            a_zero_delay: assert property (@(posedge hclk) disable iff (!hresetn)
                (state == S_IDLE) && cond[i] && (dcnt == 9'h000) |=> (state == S_FAULT) ##1 active[i])
                else $error("zero delay fault not taken at once");
            a_retry_limit: assert property (@(posedge hclk) disable iff (!hresetn)
                (state == S_FAULT) && (cfg[i].retries == RETRY_NONE) |=> (state == S_LATCH))
                else $error("no-retry fault did not latch");
            a_latch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
                (state == S_LATCH) && pin_fall |=> (state == S_IDLE))
                else $error("pin cycle did not clear latch");
        end
    endgenerate

    wire enable_req = op_enable & s.ctrl_pin;
    wire init_block = ~mod_started & (|s.stage_temp_low);
    wire run        = enable_req & vin_ok & ~init_block & ~(|active);

    // Input window and start-up checks
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vin_ok      <= 1'b0;
            mod_started <= 1'b0;
        end
        else
        begin
            vin_ok      <= s.vin_above_on | (vin_ok & ~s.vin_below_off);
            mod_started <= enable_req & (mod_started | run);
        end
    end

    wire next_hiz   = |act_hiz;
    wire next_low   = ~next_hiz & (|act_low);
    wire next_soft  = ~next_hiz & ~next_low & ((|act_soft) | (mod_started & ~vin_ok));
    wire next_en    = (run | next_soft) & ~next_hiz & ~next_low;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            modulator_enable <= 1'b0;
            pwm_tristate     <= 1'b1;
            pwm_force_low    <= 1'b0;
            softoff_req      <= 1'b0;
        end
        else
        begin
            modulator_enable <= next_en;
            pwm_tristate     <= next_hiz | ~next_en;
            pwm_force_low    <= next_low;
            softoff_req      <= next_soft;
        end
    end

    a_hiz_priority: assert property (@(posedge hclk) disable iff (!hresetn)
        (|act_hiz) |=> pwm_tristate && !pwm_force_low && !softoff_req && !modulator_enable)
        else $error("tristate response not exclusive");
    a_low_response: assert property (@(posedge hclk) disable iff (!hresetn)
        (|act_low) && !(|act_hiz) |=> pwm_force_low && !softoff_req)
        else $error("low response not applied");
    a_low_input: assert property (@(posedge hclk) disable iff (!hresetn)
        !vin_ok && !(|act_soft) && !mod_started |=> !modulator_enable)
        else $error("output enabled below turn-on level");
    a_init_block: assert property (@(posedge hclk) disable iff (!hresetn)
        init_block && !(|act_soft) |=> !modulator_enable ##1 !$rose(mod_started) || !init_block)
        else $error("output enabled with stage temperature low");

    // AHB-Lite slave, zero wait states
    wire       take   = hsel & hready & htrans[1] & (hsize == 3'b010);
    wire       is_cfg = (addr_q[7:5] == A_CFG[7:5]);
    wire [2:0] cfg_ix = addr_q[4:2];
    wire [7:0] rd_ix  = haddr[7:0];
    wire [11:0] stage_set = {s.stage_temp_low & ~{NSTAGE{mod_started}}, s.stage_hot, s.stage_fault_ind};
    wire [11:0] stage_clr = (wr_q && addr_q == A_STAGE) ? hwdata[11:0] : 12'h000;
    wire [15:0] status_word = {softoff_req, pwm_force_low, pwm_tristate, modulator_enable,
                               init_block, ~vin_ok, ov_warn, uv_warn, active};

    always_comb
    begin
        rd_word = 32'h00000000;
        if (rd_ix[7:5] == A_CFG[7:5])
            rd_word = {7'h00, cfg[rd_ix[4:2]]};
        else
        begin
            case (rd_ix)
                A_CONTROL:  rd_word = {31'h00000000, op_enable};
                A_STATUS:   rd_word = {16'h0000, status_word};
                A_STAGE:    rd_word = {20'h00000, stage_status};
                A_VUV_WRN:  rd_word = {20'h00000, vuv_wrn};
                A_VUV_FLT:  rd_word = {20'h00000, vuv_flt};
                A_VOV_WRN:  rd_word = {20'h00000, vov_wrn};
                A_IOUT_LIM: rd_word = {20'h00000, iout_lim};
                A_RAMP:     rd_word = {24'h000000, ramp_down_rate};
                default:    rd_word = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            hrdata       <= '0;
            addr_q       <= '0;
            wr_q         <= 1'b0;
            stage_status <= '0;
        end
        else
        begin
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            wr_q         <= take & hwrite;
            addr_q       <= take ? haddr[7:0] : addr_q;
            hrdata       <= (take && !hwrite) ? rd_word : hrdata;
            stage_status <= (stage_status & ~stage_clr) | stage_set;
        end
    end

    a_stage_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        s.stage_fault_ind[0] |=> stage_status[0] ##1 (stage_status[0] || $past(stage_clr[0])))
        else $error("stage fault status not kept");

    // Writable configuration
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            op_enable      <= CONTROL_RESET;
            vuv_wrn        <= VUV_WRN_RESET;
            vuv_flt        <= VUV_FLT_RESET;
            vov_wrn        <= VOV_WRN_RESET;
            iout_lim       <= IOUT_LIM_RESET;
            ramp_down_rate <= RAMP_RESET;
        end
        else if (wr_q && !is_cfg)
        begin
            case (addr_q)
                A_CONTROL:  op_enable      <= hwdata[0];
                A_VUV_WRN:  vuv_wrn        <= hwdata[11:0];
                A_VUV_FLT:  vuv_flt        <= hwdata[11:0];
                A_VOV_WRN:  vov_wrn        <= hwdata[11:0];
                A_IOUT_LIM: iout_lim       <= hwdata[11:0];
                A_RAMP:     ramp_down_rate <= hwdata[7:0];
                default:    op_enable      <= op_enable;
            endcase
        end
    end

    generate
        for (genvar i = 0; i < NSRC; i++)
        begin : g_cfg
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    cfg[i] <= default_cfg(i);
                else if (wr_q && is_cfg && (cfg_ix == 3'(i)))
                    cfg[i] <= cfg_t'(hwdata[24:0]);
            end
        end
    endgenerate
endmodule : power_fault_supervisor
